// ===== rtl/instruction_clock_watchdog.sv
// Purpose: Watchdog that resets a small processor after a program run-away
// Assumes: Core gives one-cycle pulses per executed instruction, all on clk
// Notes:   Reset output is active low and stays low until system reset
`timescale 1ns/1ps
`include "wdog_consts.svh"

// Operation
// - After reset load counter with all ones, decrement each instruction clock.
// - A count pulse at zero is an underflow and, while enabled, sets the first flag.
// - Enabled underflow with first flag still set sets second flag, drives reset low.
// - Enable flag is set by system reset and in RAM back-up mode.
// - Disable instruction directly followed by service instruction clears enable.
// - Disable instruction alone leaves watchdog running and enable unchanged.
// - Service with first flag set clears it and skips the next instruction.
// - Service with first flag clear does not skip.
// - Skip behaviour still works while the watchdog is disabled.
// - Entering power down initializes first flag and counter.
module instruction_clock_watchdog (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic instruction_clock,
  input  wire logic instr_valid,
  input  wire logic wdog_service_instr,
  input  wire logic wdog_disable_instr,
  input  wire logic power_down_entry,
  input  wire logic ram_backup_mode,
  output logic      skip_next_ff,
  output logic      sys_reset_n_ff,
  output logic      wdog_enable_flag_ff,
  output logic      first_underflow_flag_ff,
  output logic      second_underflow_flag_ff
);
  wdog_pkg::disable_seq_t seq_ff;
  wdog_pkg::disable_seq_t nxt_seq;
  wdog_pkg::wdog_count_t  wdog_count;
  wire logic              underflow;
  wire logic              service;
  wire logic              disable_pair;
  wire logic              nxt_first;
  wire logic              nxt_second;
  wire logic              nxt_enable;

  // Counter is held at the start value while power down entry is signalled
  wdog_down_counter u_counter (
    .clk       (clk),
    .rst       (rst),
    .init      (power_down_entry),
    .step      (instruction_clock),
    .count     (wdog_count),
    .underflow (underflow)
  );

  // Instruction decode; only executed instructions count
  assign service      = instr_valid & wdog_service_instr;
  assign disable_pair = service & (seq_ff == wdog_pkg::SEQ_AFTER_DISABLE);

  // Any other executed instruction breaks the disable pair
  always_comb begin
    nxt_seq = seq_ff;
    if (instr_valid) begin
      case (seq_ff)
        wdog_pkg::SEQ_IDLE,
        wdog_pkg::SEQ_AFTER_DISABLE: begin
          nxt_seq = wdog_disable_instr ? wdog_pkg::SEQ_AFTER_DISABLE
                                       : wdog_pkg::SEQ_IDLE;
        end
        default: begin
          nxt_seq = wdog_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Underflow sets even in the service cycle: the set wins over the clear
  assign nxt_first  = power_down_entry ? `WDOG_FLAG_RESET
                    : ((underflow & wdog_enable_flag_ff)
                       | (first_underflow_flag_ff & ~service));
  assign nxt_second = second_underflow_flag_ff
                    | (underflow & wdog_enable_flag_ff & first_underflow_flag_ff);
  assign nxt_enable = ram_backup_mode ? `WDOG_ENABLE_RESET
                    : (wdog_enable_flag_ff & ~disable_pair);

  // Flags and sequence tracker
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_ff                   <= wdog_pkg::SEQ_IDLE;
      first_underflow_flag_ff  <= `WDOG_FLAG_RESET;
      second_underflow_flag_ff <= `WDOG_FLAG_RESET;
      wdog_enable_flag_ff      <= `WDOG_ENABLE_RESET;
    end else begin
      seq_ff                   <= nxt_seq;
      first_underflow_flag_ff  <= nxt_first;
      second_underflow_flag_ff <= nxt_second;
      wdog_enable_flag_ff      <= nxt_enable;
    end
  end

  // Skip request is independent of the enable flag so it works when disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_next_ff   <= 1'h0;
      sys_reset_n_ff <= 1'h1;
    end else begin
      skip_next_ff   <= service & first_underflow_flag_ff;
      sys_reset_n_ff <= ~nxt_second;
    end
  end

  // Checker helper: was the last executed instruction a disable? Kept apart from
  // seq_ff so that the pair check does not lean on the logic it guards
  logic chk_after_disable_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      chk_after_disable_ff <= 1'h0;
    end else if (instr_valid) begin
      chk_after_disable_ff <= wdog_disable_instr;
    end
  end

  // Reset state: no disable iff here, so the values held under reset are seen
  a_reset_state: assert property (@(posedge clk)
    rst |=> wdog_enable_flag_ff && sys_reset_n_ff && !skip_next_ff
      && !first_underflow_flag_ff && !second_underflow_flag_ff
      && wdog_count == `WDOG_CNT_INIT)
    else $error("reset did not give the start state");

  // Counter: one step per count pulse, wrap at zero, reload on power down, no other movement
  a_counter_steps: assert property (@(posedge clk) disable iff (rst)
    instruction_clock && !power_down_entry
      |=> wdog_count == $past(wdog_count) - 16'h0001)
    else $error("counter did not step down by one");

  a_counter_wraps: assert property (@(posedge clk) disable iff (rst)
    instruction_clock && !power_down_entry && wdog_count == `WDOG_CNT_ZERO
      |=> wdog_count == `WDOG_CNT_INIT && underflow)
    else $error("counter did not wrap with an underflow");

  a_counter_holds: assert property (@(posedge clk) disable iff (rst)
    !instruction_clock && !power_down_entry |=> $stable(wdog_count))
    else $error("counter moved without a count pulse");

  a_power_down_init: assert property (@(posedge clk) disable iff (rst)
    power_down_entry
      |=> !first_underflow_flag_ff && wdog_count == `WDOG_CNT_INIT && !underflow)
    else $error("power down did not initialize");

  // First flag and reset output
  a_underflow_sets_first: assert property (@(posedge clk) disable iff (rst)
    underflow && wdog_enable_flag_ff && !power_down_entry |=> first_underflow_flag_ff)
    else $error("underflow did not set first flag");

  a_first_needs_underflow: assert property (@(posedge clk) disable iff (rst)
    !first_underflow_flag_ff && !(underflow && wdog_enable_flag_ff)
      |=> !first_underflow_flag_ff)
    else $error("first flag set without an underflow");

  a_second_drives_reset: assert property (@(posedge clk) disable iff (rst)
    underflow && wdog_enable_flag_ff && first_underflow_flag_ff
      |=> second_underflow_flag_ff && !sys_reset_n_ff)
    else $error("second underflow did not assert reset");

  a_reset_holds_low: assert property (@(posedge clk) disable iff (rst)
    !sys_reset_n_ff |=> !sys_reset_n_ff)
    else $error("reset output released without system reset");

  a_reset_stays_high: assert property (@(posedge clk) disable iff (rst)
    sys_reset_n_ff && !(underflow && wdog_enable_flag_ff && first_underflow_flag_ff)
      |=> sys_reset_n_ff)
    else $error("reset output fell without a second underflow");

  a_reset_matches_second: assert property (@(posedge clk) disable iff (rst)
    sys_reset_n_ff == !second_underflow_flag_ff)
    else $error("reset output and second flag disagree");

  // Enable flag: cleared only by the disable pair, set again by back-up mode
  a_disable_pair_clears: assert property (@(posedge clk) disable iff (rst)
    chk_after_disable_ff && instr_valid && wdog_service_instr && !ram_backup_mode
      |=> !wdog_enable_flag_ff)
    else $error("disable then service did not clear enable");

  a_disable_alone_keeps: assert property (@(posedge clk) disable iff (rst)
    wdog_enable_flag_ff && instr_valid && !wdog_service_instr |=> wdog_enable_flag_ff)
    else $error("enable flag cleared without service");

  a_broken_pair_keeps: assert property (@(posedge clk) disable iff (rst)
    wdog_enable_flag_ff && instr_valid && wdog_service_instr && !chk_after_disable_ff
      |=> wdog_enable_flag_ff)
    else $error("service without a disable before it cleared enable");

  a_disabled_stays: assert property (@(posedge clk) disable iff (rst)
    !wdog_enable_flag_ff && !ram_backup_mode |=> !wdog_enable_flag_ff)
    else $error("enable flag set again without back-up mode");

  a_backup_enables: assert property (@(posedge clk) disable iff (rst)
    ram_backup_mode |=> wdog_enable_flag_ff)
    else $error("back-up mode did not set enable");

  // Skip pulse
  a_service_skips: assert property (@(posedge clk) disable iff (rst)
    instr_valid && wdog_service_instr && first_underflow_flag_ff
      |=> skip_next_ff && (!first_underflow_flag_ff || $past(underflow)))
    else $error("service with flag set did not skip and clear");

  a_service_no_skip: assert property (@(posedge clk) disable iff (rst)
    !(instr_valid && wdog_service_instr && first_underflow_flag_ff) |=> !skip_next_ff)
    else $error("skip without flag set");

  a_skip_while_disabled: assert property (@(posedge clk) disable iff (rst)
    !wdog_enable_flag_ff && instr_valid && wdog_service_instr && first_underflow_flag_ff
      |=> skip_next_ff)
    else $error("skip lost while the watchdog is disabled");

  // Main scenarios
  c_first_underflow: cover property (@(posedge clk) disable iff (rst)
    $rose(first_underflow_flag_ff));
  c_watchdog_reset: cover property (@(posedge clk) disable iff (rst)
    $fell(sys_reset_n_ff));
  c_disabled: cover property (@(posedge clk) disable iff (rst)
    $fell(wdog_enable_flag_ff));
  c_skip: cover property (@(posedge clk) disable iff (rst) skip_next_ff);
  c_skip_disabled: cover property (@(posedge clk) disable iff (rst)
    skip_next_ff && !wdog_enable_flag_ff);
endmodule

// ===== rtl/wdog_consts.svh
// Purpose: Timing counts and reset values for the instruction clock watchdog
// Assumes: Included by bare name from the watchdog design files
// Notes:   Definitions only
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH

`define WDOG_CNT_W        16
`define WDOG_CNT_INIT     16'hFFFF
`define WDOG_CNT_ZERO     16'h0000
`define WDOG_SERVICE_MAX  65534
`define WDOG_FLAG_RESET   1'h0
`define WDOG_ENABLE_RESET 1'h1

`endif

// ===== rtl/wdog_pkg.sv
// Purpose: Types shared by the watchdog design files
// Assumes: Widths come from the constants header
// Notes:   No import; users write wdog_pkg::name
`include "wdog_consts.svh"
package wdog_pkg;
  typedef logic [`WDOG_CNT_W-1:0] wdog_count_t;
  // Tracks whether the previous executed instruction was the disable instruction
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_AFTER_DISABLE
  } disable_seq_t;
endpackage

// ===== rtl/wdog_down_counter.sv
// Purpose: 16-bit down-counter stepped by the instruction clock
// Assumes: Step and init are single-cycle pulses in the clk domain
// Notes:   Wraps from zero to all ones and flags the underflow
`timescale 1ns/1ps
`include "wdog_consts.svh"
module wdog_down_counter (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 init,
  input  wire logic                 step,
  output wdog_pkg::wdog_count_t     count,
  output logic                      underflow
);
  wdog_pkg::wdog_count_t count_ff;
  logic                  underflow_ff;
  wire logic             at_zero;
  wire wdog_pkg::wdog_count_t nxt_count;

  // Zero minus one wraps naturally to all ones
  assign at_zero   = (count_ff == `WDOG_CNT_ZERO);
  assign nxt_count = init ? `WDOG_CNT_INIT
                   : (step ? count_ff - 16'h0001 : count_ff);

  // Reset and power-down entry both reload the start value
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff     <= `WDOG_CNT_INIT;
      underflow_ff <= 1'h0;
    end else begin
      count_ff     <= nxt_count;
      underflow_ff <= ~init & step & at_zero;
    end
  end

  assign count     = count_ff;
  assign underflow = underflow_ff;
endmodule

// ===== testbench/core_model.sv
// Purpose: Processor core model issuing watchdog instructions
// Assumes: Tasks are called just after a falling clk edge
// Notes:   Each instruction is a one-cycle valid pulse
`timescale 1ns/1ps
module core_model (
  input  wire logic clk,
  output logic      instr_valid,
  output logic      service,
  output logic      disable_i
);
  initial {instr_valid, service, disable_i} = 3'h0;
  // Op 0 is any other instruction, 1 service, 2 disable
  task automatic exec(input logic [1:0] op);
    {instr_valid, service, disable_i} = {1'h1, op == 2'h1, op == 2'h2};
    @(negedge clk);
  endtask
  // No instruction this cycle
  task automatic idle();
    {instr_valid, service, disable_i} = 3'h0;
    @(negedge clk);
  endtask
  // A no-op trails the service so that a skip costs nothing
  task automatic service_nop();
    exec(2'h1);
    exec(2'h0);
    idle();
  endtask
endmodule

// ===== testbench/instruction_clock_watchdog_test.sv
// Purpose: Self-checking bench for the instruction clock watchdog
// Assumes: Inputs change at the falling clk edge
// Notes:   Expected results wait in a queue keyed by cycle number
`timescale 1ns/1ps
module instruction_clock_watchdog_test;
  typedef struct {int c; int s; logic v;} note_t;
  logic       clk = 1'h0;
  logic       rst, icl, pd, rbm, valid, srv, dis;
  wire [4:0]  obs;
  int         cyc = 0;
  int         gap;
  int         error_cnt = 0;
  int         n_compared = 0;
  note_t      q[$];
  instruction_clock_watchdog i_dut (.clk(clk), .rst(rst), .instruction_clock(icl),
    .instr_valid(valid), .wdog_service_instr(srv), .wdog_disable_instr(dis),
    .power_down_entry(pd), .ram_backup_mode(rbm), .skip_next_ff(obs[0]),
    .sys_reset_n_ff(obs[1]), .wdog_enable_flag_ff(obs[2]),
    .first_underflow_flag_ff(obs[3]), .second_underflow_flag_ff(obs[4]));
  core_model i_core (.clk(clk), .instr_valid(valid), .service(srv), .disable_i(dis));
  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Output index: 0 skip, 1 reset_n, 2 enable, 3 first flag, 4 second flag
  task automatic note(input int dc, input int s, input logic v);
    q.push_back('{cyc + dc, s, v});
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    error_cnt += q.size();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Notes are checked at the falling edge, where outputs have settled
  always @(negedge clk) begin
    for (int i = q.size() - 1; i >= 0; i--) begin
      if (q[i].c == cyc) begin
        cmp_bit(obs[q[i].s], q[i].v);
        q.delete(i);
      end
    end
  end
  // A run of about 66k cycles; 90k means a hang
  initial begin
    #(90000 * 50);
    error_cnt++;
    test_done();
  end
  initial begin
    {rst, icl, pd, rbm} = 4'h8;
    void'($urandom(95115));
    repeat (20) @(negedge clk);
    rst = 1'h0;
    note(1, 2, 1'h1);
    note(1, 3, 1'h0);
    note(1, 1, 1'h1);
    i_core.idle();
    // Service on a clear first flag must not skip
    note(1, 0, 1'h0);
    i_core.exec(2'h1);
    // A disable broken by another instruction leaves the watchdog on
    i_core.exec(2'h2);
    i_core.exec(2'h0);
    note(2, 2, 1'h1);
    i_core.exec(2'h1);
    i_core.idle();
    // Random count pulses, then power down puts the counter back to all ones
    repeat (20 + $urandom % 200) begin
      icl = 1'($urandom);
      @(negedge clk);
    end
    {icl, pd} = 2'h1;
    @(negedge clk);
    {icl, pd} = 2'h2;
    // The underflow is seen 65537 edges after power down; disable, a random idle
    // gap and a service meet it, then a second service finds the flag set while
    // the watchdog is already off
    gap = $urandom % 4;
    note(65536, 3, 1'h0);
    note(65537, 3, 1'h1);
    note(65537, 4, 1'h0);
    note(65537, 0, 1'h0);
    note(65537, 2, 1'h0);
    note(65538, 0, 1'h1);
    note(65538, 3, 1'h0);
    note(65538, 2, 1'h0);
    note(65539, 0, 1'h0);
    repeat (65535 - gap) @(negedge clk);
    i_core.exec(2'h2);
    repeat (gap) i_core.idle();
    i_core.exec(2'h1);
    i_core.service_nop();
    // Back-up mode forces the enable flag on again; the serviced run never reset
    rbm = 1'h1;
    note(1, 2, 1'h1);
    note(3, 2, 1'h1);
    note(3, 1, 1'h1);
    note(3, 4, 1'h0);
    repeat (2) @(negedge clk);
    rbm = 1'h0;
    repeat (4) @(negedge clk);
    test_done();
  end
endmodule
